// ### flash_cmd_ctrl.sv
// Command interpreter: register writes, quad command mode, suspend and resume
`timescale 1ns/1ps
module flash_cmd_ctrl #(
	parameter int unsigned SUS_CYCLES = flash_cmd_pkg::SUS_CYCLES_DEF
) (
	input  wire logic       clk_sys_in,     // System clock, 125 MHz
	input  wire logic       sys_rst_in,     // Synchronous reset, active high
	input  wire logic       cs_n_pin_in,    // Chip select from host, active low
	input  wire logic       sck_pin_in,     // Serial clock from host
	input  wire logic [3:0] io_pin_in,      // Data pins in, io[0] is serial in
	output logic      [3:0] io_out,         // Data pins out, io[1] is serial out
	output logic      [3:0] io_oe_out,      // Data pin drive enables
	input  wire logic       op_busy_in,     // Array engine holds an operation
	input  wire logic [1:0] op_kind_in,     // Kind of that operation
	output logic [7:0]      status_reg_out, // Status register
	output logic [7:0]      func_reg_out,   // Function register
	output logic            quad_cmd_mode_out, // Four-bit command mode
	output logic            suspend_req_out,   // Pulse: pause array engine
	output logic            resume_req_out,    // Pulse: restart array engine
	output logic            cmd_valid_out,     // Pulse: opcode handed to engine
	output logic [7:0]      cmd_code_out       // Opcode handed to engine
);

	typedef enum logic [2:0] {FR_IDLE, FR_OPCODE, FR_DATA, FR_SHOUT, FR_SKIP} frame_type;

	// ==========================================
	// Pin sampling and edge detection
	logic [5:0] pins_s;
	logic       sck_q;
	logic       cs_n_q;
	logic       busy_q;

	link_sync #(.W(6)) u_sync (
		.clk_sys_in (clk_sys_in),
		.sys_rst_in (sys_rst_in),
		.async_in   ({cs_n_pin_in, sck_pin_in, io_pin_in}),
		.sync_out   (pins_s)
	);

	wire       cs_n_s    = pins_s[5];
	wire       sck_s     = pins_s[4];
	wire [3:0] io_s      = pins_s[3:0];
	wire       sck_rise  = sck_s & ~sck_q & ~cs_n_s;
	wire       sck_fall  = ~sck_s & sck_q & ~cs_n_s;
	wire       frame_beg = ~cs_n_s & cs_n_q;
	wire       frame_end = cs_n_s & ~cs_n_q;
	wire       busy_fall = busy_q & ~op_busy_in;

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			sck_q  <= 1'b0;
			cs_n_q <= 1'b1;
			busy_q <= 1'b0;
		end else begin
			sck_q  <= sck_s;
			cs_n_q <= cs_n_s;
			busy_q <= op_busy_in;
		end
	end

	// ==========================================
	// Register state
	logic [3:0]  bp_q;
	logic        status_write_disable_q;
	logic        qe_q;
	logic        wel_q;
	logic        wip_q;
	logic        rst_dis_q;
	logic [3:0]  irl_q;
	logic        program_suspended_flag_q;
	logic        erase_suspended_flag_q;
	logic        qpi_q;
	logic [15:0] settle_q;

	wire suspended = program_suspended_flag_q | erase_suspended_flag_q;
	wire settling  = (settle_q != 16'h0000);

	// ==========================================
	// Shift-in of opcode and data byte
	frame_type   st_q;
	logic [7:0]  shift_q;
	logic [3:0]  cnt_q;
	logic [7:0]  op_q;
	logic        op_ok_q;
	logic [7:0]  data_q;
	logic        data_ok_q;

	logic [7:0] shift_d;
	logic [3:0] cnt_d;
	logic       byte_done;
	logic       accept;

	// Quad mode takes a nibble per clock, high nibble first
	always_comb begin
		if (qpi_q) begin
			shift_d = {shift_q[3:0], io_s};
			cnt_d   = cnt_q + 4'h4;
		end else begin
			shift_d = {shift_q[6:0], io_s[0]};
			cnt_d   = cnt_q + 4'h1;
		end
		byte_done = sck_rise && (cnt_d == 4'h8);
	end

	// While settling only polling of the progress bit gets through
	always_comb begin
		accept = (!settling || shift_d == flash_cmd_pkg::STATUS_READ_CMD)
			&& (!suspended || flash_cmd_pkg::suspend_allows(shift_d, erase_suspended_flag_q));
	end

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			st_q      <= FR_IDLE;
			shift_q   <= 8'h00;
			cnt_q     <= 4'h0;
			op_q      <= 8'h00;
			op_ok_q   <= 1'b0;
			data_q    <= 8'h00;
			data_ok_q <= 1'b0;
		end else if (cs_n_s) begin
			st_q      <= FR_IDLE;
			cnt_q     <= 4'h0;
		end else begin
			if (frame_beg) begin
				st_q      <= FR_OPCODE;
				op_ok_q   <= 1'b0;
				data_ok_q <= 1'b0;
			end
			if (sck_rise) begin
				shift_q <= shift_d;
				cnt_q   <= byte_done ? 4'h0 : cnt_d;
			end
			if (byte_done) begin
				unique case (st_q)
					FR_OPCODE: begin
						op_q    <= shift_d;
						op_ok_q <= accept;
						if (!accept) begin
							st_q <= FR_SKIP;
						end else if (shift_d == flash_cmd_pkg::STATUS_WRITE_CMD ||
							shift_d == flash_cmd_pkg::FUNC_REG_WRITE_CMD) begin
							st_q <= FR_DATA;
						end else if (shift_d == flash_cmd_pkg::STATUS_READ_CMD ||
							shift_d == flash_cmd_pkg::FUNC_REG_READ_CMD) begin
							st_q <= FR_SHOUT;
						end else begin
							st_q <= FR_SKIP;
						end
					end
					FR_DATA: begin
						data_q    <= shift_d;
						data_ok_q <= 1'b1;
						st_q      <= FR_SKIP;
					end
					FR_IDLE, FR_SHOUT, FR_SKIP: begin
					end
				endcase
			end
		end
	end

	// ==========================================
	// Shift-out of status and function registers
	logic [7:0] out_q;
	logic [2:0] ocnt_q;
	logic [7:0] live_reg;
	logic [7:0] out_v;

	always_comb begin
		if (op_q == flash_cmd_pkg::FUNC_REG_READ_CMD) begin
			live_reg = func_reg_out;
		end else begin
			live_reg = status_reg_out;
		end
		// Reload at each byte so a polling host sees fresh progress
		out_v = (ocnt_q == 3'h0) ? live_reg : out_q;
	end

	// Data changes on the falling edge so the host samples it on the rise
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in || cs_n_s) begin
			io_out    <= 4'h0;
			io_oe_out <= 4'h0;
			out_q     <= 8'h00;
			ocnt_q    <= 3'h0;
		end else if (sck_fall && st_q == FR_SHOUT) begin
			if (qpi_q) begin
				io_out    <= out_v[7:4];
				io_oe_out <= 4'hF;
				out_q     <= {out_v[3:0], 4'h0};
				ocnt_q    <= ocnt_q + 3'h4;
			end else begin
				io_out    <= {2'b00, out_v[7], 1'b0};
				io_oe_out <= 4'h2;
				out_q     <= {out_v[6:0], 1'b0};
				ocnt_q    <= ocnt_q + 3'h1;
			end
		end
	end

	// ==========================================
	// Command execution at the end of the frame
	wire exec      = frame_end && op_ok_q;
	wire is_wen    = op_q == flash_cmd_pkg::WRITE_ENABLE_CMD;
	wire is_wdis   = op_q == flash_cmd_pkg::WRITE_DISABLE_CMD;
	wire is_swr    = op_q == flash_cmd_pkg::STATUS_WRITE_CMD;
	wire is_fwr    = op_q == flash_cmd_pkg::FUNC_REG_WRITE_CMD;
	wire is_susp   = op_q == flash_cmd_pkg::SUSPEND_CMD_A || op_q == flash_cmd_pkg::SUSPEND_CMD_B;
	wire is_resume = op_q == flash_cmd_pkg::RESUME_CMD_A || op_q == flash_cmd_pkg::RESUME_CMD_B;

	// Suspend only an engine that is running, never a chip erase
	wire do_susp   = exec && is_susp && op_busy_in && !suspended
		&& op_kind_in != flash_cmd_pkg::OP_CHIP_ERASE;
	wire do_resume = exec && is_resume && suspended;
	// Writes that complete with a partial data byte are dropped
	wire do_swr    = exec && is_swr && data_ok_q && wel_q
		&& !suspended;
	wire do_fwr    = exec && is_fwr && data_ok_q && wel_q;

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			bp_q   <= 4'h0;
			status_write_disable_q <= 1'b0;
			qe_q   <= 1'b0;
		end else if (do_swr) begin
			bp_q   <= data_q[flash_cmd_pkg::BP_LSB +: 4];
			status_write_disable_q <= data_q[flash_cmd_pkg::STATUS_WRITE_DISABLE_BIT];
			qe_q   <= data_q[flash_cmd_pkg::QE_BIT];
		end
	end

	// One-time bits only ever gain ones
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			rst_dis_q <= 1'b0;
			irl_q     <= 4'h0;
		end else if (do_fwr) begin
			rst_dis_q <= rst_dis_q | data_q[flash_cmd_pkg::RSTD_BIT];
			irl_q     <= irl_q | data_q[flash_cmd_pkg::IRL_LSB +: 4];
		end
	end

	// Latch set by write enable; cleared by disable, writes, suspend, completion
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			wel_q <= 1'b0;
		end else if (exec && is_wen) begin
			wel_q <= 1'b1;
		end else if ((exec && is_wdis) || do_swr || do_fwr || busy_fall) begin
			wel_q <= 1'b0;
		end else if (do_susp) begin
			wel_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			program_suspended_flag_q <= 1'b0;
			erase_suspended_flag_q <= 1'b0;
		end else if (do_susp) begin
			program_suspended_flag_q <= (op_kind_in == flash_cmd_pkg::OP_PROGRAM);
			erase_suspended_flag_q <= (op_kind_in == flash_cmd_pkg::OP_ERASE);
		end else if (do_resume) begin
			program_suspended_flag_q <= 1'b0;
			erase_suspended_flag_q <= 1'b0;
		end
	end

	// Hold-off after a suspend while the engine parks; long enough to shorten
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			settle_q <= 16'h0000;
		end else if (do_susp) begin
			settle_q <= 16'(SUS_CYCLES - 1);
		end else if (settling) begin
			settle_q <= settle_q - 16'h0001;
		end
	end

	// Progress bit: engine running and not parked, or parking in progress
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			wip_q <= 1'b0;
		end else begin
			wip_q <= (op_busy_in && !suspended) || settling || do_susp;
		end
	end

	// Only a power cycle or the exit opcode leaves quad mode
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			qpi_q <= 1'b0;
		end else if (exec && !qpi_q && op_q == flash_cmd_pkg::QUAD_ENTRY_CMD) begin
			qpi_q <= 1'b1;
		end else if (exec && qpi_q && op_q == flash_cmd_pkg::QUAD_EXIT_CMD) begin
			qpi_q <= 1'b0;
		end
	end

	// ==========================================
	// Hand-off to the array engine
	wire handed = byte_done && st_q == FR_OPCODE && accept
		&& (!flash_cmd_pkg::needs_wel(shift_d) || wel_q);
	// Refused opcodes never reach the engine, so suspended work is untouched
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			cmd_valid_out   <= 1'b0;
			cmd_code_out    <= 8'h00;
			suspend_req_out <= 1'b0;
			resume_req_out  <= 1'b0;
		end else begin
			cmd_valid_out   <= handed;
			if (handed) begin
				cmd_code_out <= shift_d;
			end
			suspend_req_out <= do_susp;
			resume_req_out  <= do_resume;
		end
	end

	// Register images are gathered from flops only
	always_comb begin
		status_reg_out = {status_write_disable_q, qe_q, bp_q, wel_q, wip_q};
		func_reg_out   = {irl_q, erase_suspended_flag_q, program_suspended_flag_q, rst_dis_q, 1'b0};
		quad_cmd_mode_out = qpi_q;
	end

endmodule

// ### flash_cmd_ctrl_props.sv
// Concurrent checks on the flash command interpreter ports
`timescale 1ns/1ps
module flash_cmd_ctrl_props #(
	parameter int unsigned SUS_CYCLES = 20
) (
	input wire logic       clk_sys_in,        // System clock
	input wire logic       sys_rst_in,        // Reset, active high
	input wire logic       cs_n_pin_in,       // Chip select
	input wire logic [3:0] io_oe_out,         // Drive enables
	input wire logic       op_busy_in,        // Engine busy
	input wire logic [1:0] op_kind_in,        // Engine operation kind
	input wire logic [7:0] status_reg_out,    // Status register
	input wire logic [7:0] func_reg_out,      // Function register
	input wire logic       quad_cmd_mode_out, // Quad mode
	input wire logic       suspend_req_out,   // Suspend pulse
	input wire logic       resume_req_out     // Resume pulse
);
	// ==========================================
	// Checks
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (sys_rst_in);

	a_wel_drop_sus: assert property ($rose(|func_reg_out[3:2]) |-> ##[0:2] !status_reg_out[1])
		else $error("latch not cleared by suspend");
	a_sus_needs_busy: assert property (suspend_req_out |-> $past(op_busy_in) && $past(op_kind_in) != 2'h2)
		else $error("suspend without suspendable operation");
	a_sus_sets_flag: assert property (suspend_req_out |-> ##[0:2] func_reg_out[3:2] != 2'b00)
		else $error("suspend flag not raised");
	a_flag_has_cause: assert property ($rose(|func_reg_out[3:2]) |->
		suspend_req_out || $past(suspend_req_out) || $past(suspend_req_out, 2))
		else $error("suspend flag without suspend");
	a_flag_bit_kind: assert property ($rose(|func_reg_out[3:2]) |->
		func_reg_out[3:2] == (($past(op_kind_in) == 2'h1) ? 2'b10 : 2'b01))
		else $error("wrong suspend flag bit");
	a_resume_clears: assert property (resume_req_out |-> ##[0:2] func_reg_out[3:2] == 2'b00)
		else $error("resume left flag set");
	a_otp_sticky: assert property ((($past(func_reg_out) & 8'hF2) & ~func_reg_out) == 8'h00)
		else $error("one-time bit cleared");
	a_wsr_gated: assert property ($changed(status_reg_out[7:2]) |->
		$past(status_reg_out[1]) && $past(func_reg_out[3:2]) == 2'b00)
		else $error("status bits changed without latch");
	a_oe_width: assert property (io_oe_out != 4'h0 |->
		io_oe_out == (quad_cmd_mode_out ? 4'hF : 4'h2))
		else $error("drive enables wrong for mode");
	a_oe_idle: assert property (cs_n_pin_in [*6] |-> io_oe_out == 4'h0)
		else $error("pins driven while deselected");
	a_wip_on_sus: assert property ($rose(|func_reg_out[3:2]) |-> ##[0:2] status_reg_out[0])
		else $error("progress bit low at suspend");
endmodule

bind flash_cmd_ctrl flash_cmd_ctrl_props #(.SUS_CYCLES(SUS_CYCLES)) i_props (
	.clk_sys_in, .sys_rst_in, .cs_n_pin_in, .io_oe_out, .op_busy_in, .op_kind_in,
	.status_reg_out, .func_reg_out, .quad_cmd_mode_out, .suspend_req_out, .resume_req_out);

// ### flash_cmd_pkg.sv
// Opcodes, register fields and timing for the flash command interpreter
package flash_cmd_pkg;

	// ==========================================
	// Opcodes
	localparam logic [7:0] WRITE_ENABLE_CMD   = 8'h06;
	localparam logic [7:0] WRITE_DISABLE_CMD  = 8'h04;
	localparam logic [7:0] STATUS_READ_CMD    = 8'h05;
	localparam logic [7:0] STATUS_WRITE_CMD   = 8'h01;
	localparam logic [7:0] FUNC_REG_READ_CMD  = 8'h48;
	localparam logic [7:0] FUNC_REG_WRITE_CMD = 8'h42;
	localparam logic [7:0] QUAD_ENTRY_CMD     = 8'h35;
	localparam logic [7:0] QUAD_EXIT_CMD      = 8'hF5;
	localparam logic [7:0] SUSPEND_CMD_A      = 8'h75;
	localparam logic [7:0] SUSPEND_CMD_B      = 8'hB0;
	localparam logic [7:0] RESUME_CMD_A       = 8'h7A;
	localparam logic [7:0] RESUME_CMD_B       = 8'h30;

	// Accepted during any suspend: array reads, latch, register and id reads, resume
	localparam logic [7:0] SUSP_OK_OPS [0:34] = '{
		8'h03, 8'h13, 8'h0B, 8'h0C, 8'hBB, 8'hBC, 8'h3B, 8'h3C, 8'hEB, 8'hEC,
		8'h6B, 8'h6C, 8'h0D, 8'h0E, 8'hBD, 8'hBE, 8'hED, 8'hEE, 8'h06, 8'h04,
		8'h05, 8'h48, 8'h16, 8'hC8, 8'h61, 8'h81, 8'hAB, 8'h9F, 8'h90, 8'hAF,
		8'h4B, 8'h5A, 8'h82, 8'h7A, 8'h30};
	localparam logic [7:0] PROGRAM_OPS [0:5] = '{8'h02, 8'h12, 8'h32, 8'h38, 8'h34, 8'h3E};
	localparam logic [7:0] ERASE_OPS [0:8] = '{
		8'h20, 8'hD7, 8'h21, 8'h52, 8'h5C, 8'hD8, 8'hDC, 8'hC7, 8'h60};

	// ==========================================
	// Register fields
	localparam int WIP_BIT  = 0;
	localparam int WEL_BIT  = 1;
	localparam int BP_LSB   = 2;
	localparam int QE_BIT   = 6;
	localparam int STATUS_WRITE_DISABLE_BIT = 7;
	localparam int RSTD_BIT = 1;
	localparam int PROGRAM_SUSPENDED_FLAG_BIT = 2;
	localparam int ERASE_SUSPENDED_FLAG_BIT = 3;
	localparam int IRL_LSB  = 4;

	// ==========================================
	// Timing
	localparam int CLK_MHZ        = 125;
	localparam int T_SUS_US       = 100;
	localparam int SUS_CYCLES_DEF = T_SUS_US * CLK_MHZ;

	typedef enum logic [1:0] {OP_PROGRAM, OP_ERASE, OP_CHIP_ERASE} op_kind_type;

	function automatic logic in_list8(input logic [7:0] op, input int which);
		logic hit;
		hit = 1'b0;
		if (which == 0) begin
			foreach (SUSP_OK_OPS[i]) hit |= (op == SUSP_OK_OPS[i]);
		end else if (which == 1) begin
			foreach (PROGRAM_OPS[i]) hit |= (op == PROGRAM_OPS[i]);
		end else begin
			foreach (ERASE_OPS[i]) hit |= (op == ERASE_OPS[i]);
		end
		return hit;
	endfunction

	// Program commands may run inside an erase suspend only
	function automatic logic suspend_allows(input logic [7:0] op, input logic erase_suspended_flag);
		return in_list8(op, 0) || (erase_suspended_flag && in_list8(op, 1));
	endfunction

	function automatic logic needs_wel(input logic [7:0] op);
		return in_list8(op, 1) || in_list8(op, 2);
	endfunction

endpackage

// ### flash_host_model.sv
// Host controller model that frames SPI and quad commands
`timescale 1ns/1ps
module flash_host_model (
	input  wire logic       clk_in,   // Bench clock, paces the link
	input  wire logic [3:0] io_in,    // Resolved data wires
	output logic            cs_n_out, // Chip select, active low
	output logic            sck_out,  // Serial clock, idle low
	output logic      [3:0] io_out    // Host data drive
);
	initial begin
		cs_n_out = 1'b1;
		sck_out = 1'b0;
		io_out = 4'h0;
	end

	// ==========================================
	// Link cycles
	// Four system clocks a half period give the 64 ns serial clock
	task automatic tick(input logic [3:0] v, output logic [3:0] r);
		io_out = v;
		repeat (4) @(negedge clk_in);
		sck_out = 1'b1;
		repeat (4) @(negedge clk_in);
		r = io_in;
		sck_out = 1'b0;
	endtask

	task automatic xfer(input logic q, input logic [7:0] op, input logic [7:0] d,
		input int n, input logic rdn, output logic [7:0] rd);
		logic [3:0] r;
		logic [7:0] b;
		rd = 8'h00;
		cs_n_out = 1'b0;
		for (int k = 0; k <= n; k++) begin
			b = (k == 0) ? op : d;
			if (q) begin
				// Released wires toggle so a stale level never reads as data
				tick((k > 0 && rdn) ? ~io_out : b[7:4], r);
				rd[7:4] = r;
				tick((k > 0 && rdn) ? ~io_out : b[3:0], r);
				rd[3:0] = r;
			end else begin
				for (int j = 7; j >= 0; j--) begin
					tick({~io_out[3:1], b[j]}, r);
					rd[j] = r[1];
				end
			end
		end
		repeat (4) @(negedge clk_in);
		cs_n_out = 1'b1;
		io_out = ~io_out;
		repeat (16) @(negedge clk_in);
	endtask
endmodule

// ### link_sync.sv
// Two-flop synchroniser for the serial link pins
`timescale 1ns/1ps
module link_sync #(
	parameter int W = 6
) (
	input  wire logic         clk_sys_in, // System clock
	input  wire logic         sys_rst_in, // Synchronous reset, active high
	input  wire logic [W-1:0] async_in,   // Pins from the host domain
	output logic      [W-1:0] sync_out    // Resynchronised pins
);

	logic [W-1:0] meta_q;

	// Reset value 1 on the top bit keeps chip select deasserted
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			meta_q   <= {1'b1, {(W-1){1'b0}}};
			sync_out <= {1'b1, {(W-1){1'b0}}};
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule

// ### test_flash_cmd_ctrl.sv
// Self-checking bench for the flash command interpreter
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin failures++; \
	$display("Error at %0t: got %0h expected %0h", $time, (a), (b)); end end
module test_flash_cmd_ctrl;
	localparam int unsigned SUS = 20;
	logic       clk_sys_in = 1'b0;
	logic       sys_rst_in = 1'b1;
	logic       op_busy = 1'b0;
	logic [1:0] op_kind = 2'h0;
	logic       quad = 1'b0;
	logic       cs_n, sck, qm, sreq, rreq, cval;
	logic [3:0] io_h, io_d, io_oe, io_w;
	logic [7:0] st, fr, code, rd;
	logic [7:0] last_code = 8'h00;
	int         failures = 0;
	int         comparisons = 0;
	int         cycles = 0;

	assign io_w = (io_oe & io_d) | (~io_oe & io_h);

	flash_cmd_ctrl #(.SUS_CYCLES(SUS)) i_flash_cmd_ctrl (
		.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .cs_n_pin_in(cs_n),
		.sck_pin_in(sck), .io_pin_in(io_w), .io_out(io_d), .io_oe_out(io_oe),
		.op_busy_in(op_busy), .op_kind_in(op_kind), .status_reg_out(st),
		.func_reg_out(fr), .quad_cmd_mode_out(qm), .suspend_req_out(sreq),
		.resume_req_out(rreq), .cmd_valid_out(cval), .cmd_code_out(code));

	flash_host_model i_flash_host_model (
		.clk_in(clk_sys_in), .io_in(io_w), .cs_n_out(cs_n), .sck_out(sck), .io_out(io_h));

	always #4 clk_sys_in = ~clk_sys_in;

	// ==========================================
	// Closing, hand-off log and hang limit
	task automatic give_verdict();
		$display("Comparisons %0d, failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	always @(posedge clk_sys_in) begin
		cycles++;
		if (cval)
			last_code <= code;
		if (cycles == 20000) begin
			failures++;
			give_verdict();
		end
	end

	task automatic cmd(input logic [7:0] op);
		i_flash_host_model.xfer(quad, op, 8'h00, 0, 1'b0, rd);
	endtask

	task automatic wr(input logic [7:0] op, input logic [7:0] d);
		i_flash_host_model.xfer(quad, op, d, 1, 1'b0, rd);
	endtask

	task automatic rdr(input logic [7:0] op);
		i_flash_host_model.xfer(quad, op, 8'h00, 1, 1'b1, rd);
	endtask

	// ==========================================
	// Tests
	initial begin
		repeat (20) @(negedge clk_sys_in);
		sys_rst_in = 1'b0;
		repeat (4) @(negedge clk_sys_in);
		`CHK(st, 8'h00)
		`CHK(fr, 8'h00)
		wr(8'h01, 8'hFC);
		`CHK(st, 8'h00)
		cmd(8'h06);
		`CHK(st, 8'h02)
		rdr(8'h05);
		`CHK(rd, 8'h02)
		wr(8'h01, 8'hFC);
		`CHK(st, 8'hFC)
		cmd(8'h06);
		wr(8'h42, 8'h12);
		`CHK(fr, 8'h12)
		cmd(8'h06);
		wr(8'h42, 8'h80);
		`CHK(fr, 8'h92)
		rdr(8'h48);
		`CHK(rd, 8'h92)
		cmd(8'h35);
		quad = 1'b1;
		`CHK(qm, 1'b1)
		rdr(8'h05);
		`CHK(rd, 8'hFC)
		cmd(8'hF5);
		quad = 1'b0;
		`CHK(qm, 1'b0)
		// Erase suspend by 75h and program suspend by B0h, resumed by 7Ah in serial mode and by 30h in quad mode
		for (int i = 0; i < 4; i++) begin
			if (i == 2) begin
				cmd(8'h35);
				quad = 1'b1;
			end
			op_kind = i[0] ? 2'h0 : 2'h1;
			op_busy = 1'b1;
			cmd(8'h06);
			cmd(i[0] ? 8'hB0 : 8'h75);
			`CHK(fr[3:2], (i[0] ? 2'b01 : 2'b10))
			`CHK(st[1:0], 2'b01)
			repeat (SUS + 10) @(negedge clk_sys_in);
			`CHK(st[0], 1'b0)
			cmd(8'h06);
			`CHK(st[1], 1'b1)
			wr(8'h01, 8'h00);
			`CHK(st[7:2], 6'h3F)
			cmd(i[0] ? 8'h02 : 8'h20);
			`CHK(last_code, 8'h06)
			cmd(8'h03);
			`CHK(last_code, 8'h03)
			cmd(i[1] ? 8'h30 : 8'h7A);
			`CHK(fr[3:2], 2'b00)
			`CHK(st[0], 1'b1)
			// Resumed operation runs to completion, which clears the latch and progress bit
			repeat (SUS) @(negedge clk_sys_in);
			op_busy = 1'b0;
			repeat (8) @(negedge clk_sys_in);
			`CHK(st[1:0], 2'b00)
		end
		cmd(8'hF5);
		quad = 1'b0;
		op_kind = 2'h2;
		op_busy = 1'b1;
		cmd(8'h06);
		cmd(8'h75);
		`CHK(fr[3:2], 2'b00)
		op_busy = 1'b0;
		repeat (8) @(negedge clk_sys_in);
		give_verdict();
	end
endmodule
